// ### logic/slave_serial_defines.vh
// constants for the slave serial configuration port
`ifndef SLAVE_SERIAL_DEFINES_VH
`define SLAVE_SERIAL_DEFINES_VH
`define MODE_SLAVE_SERIAL 3'h7
`define PREAMBLE_CODE 4'h2
`define PREAMBLE_IDLE 4'hf
`define LEN_WIDTH 24
`define LEN_BITS 5'h18
`define STARTUP_DELAY 2'h2
`define ST_IDLE 3'h0
`define ST_HUNT 3'h1
`define ST_LENGTH 3'h2
`define ST_LOAD 3'h3
`define ST_PASS 3'h4
`define ST_DONE 3'h5
`endif

// ### logic/edge_sync.v
// two-flop synchroniser with edge detection for one external level
`timescale 1ns/10ps
module edge_sync
(
	input wire clock,
	input wire rst_b,
	input wire din,
	output wire level,
	output wire rise,
	output wire fall
);
reg meta_r;
reg sync_r;
reg prev_r;
always @(posedge clock or negedge rst_b)
begin
	if (!rst_b)
	begin
		meta_r <= 1'b0;
		sync_r <= 1'b0;
		prev_r <= 1'b0;
	end
	else
	begin
		meta_r <= din;
		sync_r <= meta_r;
		prev_r <= sync_r;
	end
end
assign level = sync_r;
assign rise = sync_r & ~prev_r;
assign fall = ~sync_r & prev_r;
endmodule // edge_sync

// ### logic/slave_serial_config_port.v
// slave serial configuration port: capture, length count, daisy-chain forwarding
//
// What this block does
// - a data bit is captured on each rising config_clock edge
// - preamble and surplus bits beyond own data are repeated on dataOut
// - dataOut changes on the falling config_clock edge, half a period late
// - slave serial is entered when mode bits 2..0 read 111
// - mode inputs carry weak pull-ups during configuration, defaulting to 111
// - header captured on 0010 preamble; dataOut high while own frames received
// - start-up when clock count equals 24-bit length; release two clocks later
`timescale 1ns/10ps
`include "slave_serial_defines.vh"
module slave_serial_config_port
(
	input wire clock,
	input wire rst_b,
	input wire config_clock,
	input wire dataIn,
	input wire mode_select_bit2,
	input wire mode_select_bit1,
	input wire mode_select_bit0,
	input wire initDone,
	input wire [`LEN_WIDTH-1:0] ownBits,
	output reg dataOut,
	output reg modePullup,
	output reg configBit,
	output reg configBitValid,
	output reg startup,
	output reg released,
	output reg lengthError
);
////////////////////////////////////////////////////////////////////////////////
wire cclkLevel;
wire cclkRise;
wire cclkFall;
wire din;
wire m2;
wire m1;
wire m0;
wire initSync;
// config_clock is an input only; edges found by oversampling
edge_sync u_config_clock
(
	.clock(clock),
	.rst_b(rst_b),
	.din(config_clock),
	.level(cclkLevel),
	.rise(cclkRise),
	.fall(cclkFall)
);
edge_sync u_din
(
	.clock(clock),
	.rst_b(rst_b),
	.din(dataIn),
	.level(din),
	.rise(),
	.fall()
);
edge_sync u_m2
(
	.clock(clock),
	.rst_b(rst_b),
	.din(mode_select_bit2),
	.level(m2),
	.rise(),
	.fall()
);
edge_sync u_m1
(
	.clock(clock),
	.rst_b(rst_b),
	.din(mode_select_bit1),
	.level(m1),
	.rise(),
	.fall()
);
edge_sync u_m0
(
	.clock(clock),
	.rst_b(rst_b),
	.din(mode_select_bit0),
	.level(m0),
	.rise(),
	.fall()
);
edge_sync u_init
(
	.clock(clock),
	.rst_b(rst_b),
	.din(initDone),
	.level(initSync),
	.rise(),
	.fall()
);
////////////////////////////////////////////////////////////////////////////////
reg [2:0] state_r;
reg [3:0] shift_r;
reg [4:0] lenCnt_r;
reg [`LEN_WIDTH-1:0] length_r;
reg [`LEN_WIDTH-1:0] clkCnt_r;
reg [`LEN_WIDTH-1:0] ownCnt_r;
reg [1:0] relCnt_r;
reg fwdBit_r;
wire slaveMode;
wire [`LEN_WIDTH-1:0] clkCntInc;
////////////////////////////////////////////////////////////////////////////////
// one more of a length-wide count; shared by the link and own-bit counters
function [`LEN_WIDTH-1:0] bump;
input [`LEN_WIDTH-1:0] value;
begin
	bump = value + {{(`LEN_WIDTH-1){1'b0}}, 1'b1};
end
endfunction
assign slaveMode = ({m2, m1, m0} == `MODE_SLAVE_SERIAL);
assign clkCntInc = bump(clkCnt_r);
always @(posedge clock or negedge rst_b)
begin
	if (!rst_b)
	begin
		state_r <= `ST_IDLE;
		shift_r <= `PREAMBLE_IDLE;
		lenCnt_r <= 5'h00;
		length_r <= {`LEN_WIDTH{1'b0}};
		clkCnt_r <= {`LEN_WIDTH{1'b0}};
		ownCnt_r <= {`LEN_WIDTH{1'b0}};
		relCnt_r <= 2'h0;
		fwdBit_r <= 1'b1;
		dataOut <= 1'b1;
		modePullup <= 1'b1;
		configBit <= 1'b0;
		configBitValid <= 1'b0;
		startup <= 1'b0;
		released <= 1'b0;
		lengthError <= 1'b0;
	end
	else
	begin
		configBitValid <= 1'b0;
		// pull-ups only while configuring; user mode owns the pins afterwards
		modePullup <= (state_r != `ST_DONE);
		if (cclkFall)
			dataOut <= fwdBit_r;
		case (state_r)
			`ST_IDLE:
			begin
				// no clocks counted until the chain has left initialisation
				if (slaveMode && initSync)
					state_r <= `ST_HUNT;
			end
			`ST_HUNT:
			begin
				if (cclkRise)
				begin
					clkCnt_r <= clkCntInc;
					shift_r <= {shift_r[2:0], din};
					fwdBit_r <= din;
					if ({shift_r[2:0], din} == `PREAMBLE_CODE)
					begin
						state_r <= `ST_LENGTH;
						lenCnt_r <= 5'h00;
					end
				end
			end
			`ST_LENGTH:
			begin
				if (cclkRise)
				begin
					clkCnt_r <= clkCntInc;
					length_r <= {length_r[`LEN_WIDTH-2:0], din};
					fwdBit_r <= din;
					lenCnt_r <= lenCnt_r + 5'h01;
					if (lenCnt_r == `LEN_BITS - 5'h01)
					begin
						state_r <= `ST_LOAD;
						ownCnt_r <= {`LEN_WIDTH{1'b0}};
						if ({length_r[`LEN_WIDTH-2:0], din} == {`LEN_WIDTH{1'b0}})
							lengthError <= 1'b1;
					end
				end
			end
			`ST_LOAD:
			begin
				if (cclkRise)
				begin
					clkCnt_r <= clkCntInc;
					configBit <= din;
					configBitValid <= 1'b1;
					fwdBit_r <= 1'b1;
					ownCnt_r <= bump(ownCnt_r);
					if (bump(ownCnt_r) == ownBits)
						state_r <= `ST_PASS;
					if (clkCntInc == length_r)
						state_r <= `ST_DONE;
				end
			end
			`ST_PASS:
			begin
				if (cclkRise)
				begin
					clkCnt_r <= clkCntInc;
					fwdBit_r <= din;
					if (clkCntInc == length_r)
						state_r <= `ST_DONE;
				end
			end
			`ST_DONE:
			begin
				startup <= 1'b1;
				// the bit that matched the length still goes out at its falling edge
				if (cclkRise)
					fwdBit_r <= 1'b1;
				if (cclkRise && !released)
				begin
					relCnt_r <= relCnt_r + 2'h1;
					if (relCnt_r == `STARTUP_DELAY - 2'h1)
						released <= 1'b1;
				end
			end
			default:
				state_r <= `ST_IDLE;
		endcase
	end
end
endmodule // slave_serial_config_port

// ### test/slave_serial_props.sv
// checker for the slave serial configuration port
`timescale 1ns/10ps
module slave_serial_props
(
	input wire clock,
	input wire rst_b,
	input wire config_clock,
	input wire dataIn,
	input wire dataOut,
	input wire modePullup,
	input wire configBit,
	input wire configBitValid,
	input wire startup,
	input wire released
);
default clocking @(posedge clock); endclocking
default disable iff (!rst_b);
// two further link rises take at least eight system clocks
sequence s_wait;
	!released [*8];
endsequence
a_one_pulse: assert property (configBitValid |=> !configBitValid)
	else $error("pulse");
a_bit_taken: assert property (configBitValid |-> configBit == $past(dataIn, 3))
	else $error("bit");
a_on_rise: assert property (configBitValid |-> $past(config_clock, 2) || $past(config_clock, 3))
	else $error("rise");
a_out_fall: assert property ($changed(dataOut) |-> !$past(config_clock, 3) || !$past(config_clock, 4))
	else $error("fall");
a_start_hold: assert property (startup |=> startup)
	else $error("start");
a_rel_stays: assert property (released |=> released)
	else $error("hold");
a_rel_order: assert property (released |-> startup)
	else $error("order");
a_rel_delay: assert property ($rose(startup) |-> s_wait ##[1:20] released)
	else $error("delay");
a_pull_config: assert property (modePullup != startup)
	else $error("pullup");
a_none_after: assert property (startup |-> !configBitValid)
	else $error("late bit");
endmodule // slave_serial_props
bind slave_serial_config_port slave_serial_props i_props
(
	.clock(clock),
	.rst_b(rst_b),
	.config_clock(config_clock),
	.dataIn(dataIn),
	.dataOut(dataOut),
	.modePullup(modePullup),
	.configBit(configBit),
	.configBitValid(configBitValid),
	.startup(startup),
	.released(released)
);

// ### test/ss_source.sv
// upstream bitstream source driving link clock and data
`timescale 1ns/10ps
module ss_source
(
	input wire clock,
	input wire initDone,
	output logic config_clock = 1'b0,
	output logic dataIn = 1'b0
);
// link period is eight system clocks: 100 ns high, 100 ns low
task send(input logic [47:0] v);
	wait (initDone);
	@(posedge clock);
	for (int i = 47; i >= 0; i--)
	begin
		dataIn <= v[i];
		repeat (4) @(posedge clock);
		config_clock <= 1'b1;
		repeat (4) @(posedge clock);
		config_clock <= 1'b0;
	end
	// idle data must not look like a held bit
	dataIn <= ~dataIn;
endtask
endmodule // ss_source

// ### test/slave_serial_config_port_tb.sv
// bench for the slave serial configuration port
`timescale 1ns/10ps
module slave_serial_config_port_tb;
logic clock = 1'b0, rst_b = 1'b0, initDone = 1'b0, config_clock, dataIn, dataOut, modePullup;
logic configBit, configBitValid, startup, released, lengthError;
logic mode_select_bit2 = 1'b1, mode_select_bit1 = 1'b1, mode_select_bit0 = 1'b1;
logic [23:0] ownBits = 24'h4;
logic [3:0] ownSeq = 4'h0;
int n_errors = 0, n_tests = 0, nOwn = 0;
slave_serial_config_port i_dut
(
	.clock(clock),
	.rst_b(rst_b),
	.config_clock(config_clock),
	.dataIn(dataIn),
	.mode_select_bit2(mode_select_bit2),
	.mode_select_bit1(mode_select_bit1),
	.mode_select_bit0(mode_select_bit0),
	.initDone(initDone),
	.ownBits(ownBits),
	.dataOut(dataOut),
	.modePullup(modePullup),
	.configBit(configBit),
	.configBitValid(configBitValid),
	.startup(startup),
	.released(released),
	.lengthError(lengthError)
);
ss_source i_src
(
	.clock(clock),
	.initDone(initDone),
	.config_clock(config_clock),
	.dataIn(dataIn)
);
initial
	forever #12.5 clock = ~clock;
// own bits as handed over, newest in bit 0
always @(posedge clock)
	if (configBitValid === 1'b1)
	begin
		nOwn++;
		ownSeq <= {ownSeq[2:0], configBit};
	end
task chk(input logic [23:0] got, exp);
	n_tests++;
	if (got !== exp)
	begin
		n_errors++;
		$display("CHECK FAILED %0t %h %h", $time, got, exp);
	end
endtask
task stop_test;
	if (n_errors == 0 && n_tests > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
task restart(input logic [2:0] m);
	@(posedge clock);
	rst_b <= 1'b0;
	initDone <= 1'b0;
	{mode_select_bit2, mode_select_bit1, mode_select_bit0} <= m;
	ownSeq <= 4'h0;
	repeat (3) @(posedge clock);
	rst_b <= 1'b1;
	initDone <= 1'b1;
	nOwn = 0;
	repeat (6) @(posedge clock);
	chk(modePullup, 24'h1);
endtask
task t_chain;
	logic [47:0] e;
	// own bits read back high; the last counted bit is low so a dropped one shows
	e = {8'hf2, 24'h28, 16'hf800};
	restart(3'h7);
	fork
		i_src.send({8'hf2, 24'h28, 16'ha800});
		for (int k = 0; k < 41; k++)
		begin
			@(posedge config_clock);
			#40;
			if (k > 0)
				chk(dataOut, e[48 - k]);
		end
	join
	repeat (9) @(posedge clock);
	chk(nOwn[23:0], 24'h4);
	chk(ownSeq, 4'ha);
	chk({startup, released, modePullup, lengthError}, 4'hc);
endtask
task t_refuse;
	restart(3'h6);
	i_src.send({8'hf2, 24'd40, 16'ha900});
	chk({nOwn[3:0], startup, dataOut}, 6'h1);
endtask
task t_zero;
	restart(3'h7);
	i_src.send({8'hf2, 40'h0});
	chk({lengthError, startup}, 2'h2);
endtask
initial
begin
	t_chain;
	t_refuse;
	t_zero;
	stop_test;
end
// three frames take about 30 us; the limit leaves ample margin
initial
begin
	#100000;
	n_errors++;
	stop_test;
end
endmodule // slave_serial_config_port_tb
